// >>> hdl/t2ctl_pkg.sv
// Package for the second general timer and the overflow toggle outputs.
// Assumes a single 125 MHz clock and an SFR-style byte register port.
package t2ctl_pkg;
	localparam int unsigned CLK_HZ = 125000000;
	localparam logic [10:0] TIMER2_CONTROL_OFFSET = 11'h418;
	localparam logic [10:0] TIMER_EXT_STATUS_OFFSET = 11'h411;
	localparam logic [10:0] TIMER2_MODE_OFFSET = 11'h419;
	localparam logic [10:0] RELOAD_LOW_OFFSET = 11'h4ca;
	localparam logic [10:0] RELOAD_HIGH_OFFSET = 11'h4cb;
	localparam logic [10:0] COUNT_LOW_OFFSET = 11'h458;
	localparam logic [10:0] COUNT_HIGH_OFFSET = 11'h459;
	localparam logic [10:0] CAPTURE_LOW_OFFSET = 11'h4cc;
	localparam logic [10:0] CAPTURE_HIGH_OFFSET = 11'h4cd;
	localparam logic [7:0] TIMER2_CONTROL_RESET = 8'h00;
	localparam logic [7:0] TIMER_EXT_STATUS_RESET = 8'h00;
	localparam logic [7:0] TIMER2_MODE_RESET = 8'h00;
	// Control register fields
	localparam int CTL_OVF = 7;
	localparam int CTL_EXF = 6;
	localparam int CTL_UART0_RX_CLOCK_SELECT = 5;
	localparam int CTL_UART0_TX_CLOCK_SELECT = 4;
	localparam int CTL_EXEN = 3;
	localparam int CTL_RUN = 2;
	localparam int CTL_CNT = 1;
	localparam int CTL_CAP = 0;
	// Mode register fields
	localparam int MOD_UART1_RX_CLOCK_SELECT = 5;
	localparam int MOD_UART1_TX_CLOCK_SELECT = 4;
	localparam int MOD_CLKOE = 1;
	localparam int MOD_DOWN_COUNT_ENABLE = 0;
	// Extended status fields
	localparam int STAT_T1OE = 2;
	localparam int STAT_T0OE = 0;
	localparam logic [15:0] COUNT_ALL_ONES = 16'hffff;
	localparam int PRESCALE_DEFAULT = 4;
	typedef enum logic [1:0] {
		T2CTL_MODE_OFF = 2'b00,
		T2CTL_MODE_RELOAD = 2'b01,
		T2CTL_MODE_CAPTURE = 2'b10,
		T2CTL_MODE_BAUD = 2'b11
	} t2ctl_mode_t;
endpackage : t2ctl_pkg

// >>> hdl/t2ctl_timer2.sv
// Second general timer with its control register, and the overflow toggle outputs.
// Assumes byte SFR port on clk_in; pins are asynchronous and get synchronised here.
// Overview of operation
// - Sixteen-bit counter counts internal timer clock or external pin events.
// - Counter-select bit picks internal timing or external event counting.
// - Overflow or underflow sets overflow flag outside baud mode and with clock-out off, which may request interrupt.
// - Three modes: auto-reload up/down, capture, baud-rate generation.
// - In baud mode overflow rate clocks either or both UARTs.
// - With trigger enabled, trigger falling edge capture or reload sets external flag.
// - External flag raises timer interrupt like overflow flag, when enabled, except in down-count mode.
// - Two toggle outputs invert on each overflow of timer 0 or 1.
// - Toggle output shares pin with that timer's count input.
// - Per-timer enable picks port latch or toggle signal for pin.
// - Toggle frequency spans oscillator/8 to oscillator/8388608 via prescaler, reload.
// - Capture mode: trigger falling edge copies count bytes into capture registers.
// - Auto-reload mode loads reload registers into counter on overflow.
// - Down counting enabled: count up while trigger high, down while low.
// - Down counting reaching reload value loads all ones, flagged as underflow.
module t2ctl_timer2
	import t2ctl_pkg::*;
#(
	parameter int PRESCALE = PRESCALE_DEFAULT
) (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic [10:0] sfr_addr_in,
	input wire logic sfr_wr_in,
	input wire logic [7:0] sfr_wdata_in,
	output logic [7:0] sfr_rdata_out,
	input wire logic t2_pin_in,
	input wire logic trigger_input_in,
	input wire logic timer0_overflow_in,
	input wire logic timer1_overflow_in,
	input wire logic timer0_port_latch_in,
	input wire logic timer1_port_latch_in,
	input wire logic timer0_pin_in,
	input wire logic timer1_pin_in,
	output logic timer0_pin_out,
	output logic timer0_pin_oe_out,
	output logic timer1_pin_out,
	output logic timer1_pin_oe_out,
	output logic timer0_count_event_out,
	output logic timer1_count_event_out,
	input wire logic timer2_int_enable_in,
	output logic timer2_irq_out,
	output logic uart0_rx_clock_out,
	output logic uart0_tx_clock_out,
	output logic uart1_rx_clock_out,
	output logic uart1_tx_clock_out
);
	logic [7:0] timer2_control_ff;
	logic [7:0] timer_extended_status_ff;
	logic [7:0] timer2_mode_register_ff;
	logic [15:0] count_ff;
	logic [15:0] reload_ff;
	logic [15:0] capture_ff;
	logic [2:0] t2_sync_ff;
	logic [2:0] trig_sync_ff;
	logic [2:0] t0_sync_ff;
	logic [2:0] t1_sync_ff;
	logic t2_level_ff;
	logic trig_level_ff;
	logic t0_level_ff;
	logic t1_level_ff;
	logic [7:0] prescale_ff;
	logic [1:0] toggle_ff;
	logic ovf_pulse_ff;
	t2ctl_mode_t mode;
	logic tick;
	logic t2_fall;
	logic trig_fall;
	logic trig_high;
	logic step;
	logic up_wrap;
	logic down_hit;
	logic baud_sel;
	logic ovf_event;
	logic ext_event;
	logic [15:0] nxt_count;

	function automatic logic agree(input logic [2:0] s);
		agree = (s[1] == s[2]);
	endfunction : agree

	// Three-stage synchronisers; a level counts once stages two and three agree
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			t2_sync_ff <= 3'h0;
			trig_sync_ff <= 3'h0;
			t0_sync_ff <= 3'h0;
			t1_sync_ff <= 3'h0;
			t2_level_ff <= 1'b0;
			trig_level_ff <= 1'b0;
			t0_level_ff <= 1'b0;
			t1_level_ff <= 1'b0;
		end else begin
			t2_sync_ff <= {t2_sync_ff[1:0], t2_pin_in};
			trig_sync_ff <= {trig_sync_ff[1:0], trigger_input_in};
			t0_sync_ff <= {t0_sync_ff[1:0], timer0_pin_in};
			t1_sync_ff <= {t1_sync_ff[1:0], timer1_pin_in};
			if (agree(t2_sync_ff)) t2_level_ff <= t2_sync_ff[2];
			if (agree(trig_sync_ff)) trig_level_ff <= trig_sync_ff[2];
			if (agree(t0_sync_ff)) t0_level_ff <= t0_sync_ff[2];
			if (agree(t1_sync_ff)) t1_level_ff <= t1_sync_ff[2];
		end
	end

	assign t2_fall = agree(t2_sync_ff) && t2_level_ff && !t2_sync_ff[2];
	assign trig_fall = agree(trig_sync_ff) && trig_level_ff && !trig_sync_ff[2];
	assign trig_high = trig_level_ff;
	// Timer 0/1 pins feed their counters only when not used as toggle outputs
	assign timer0_count_event_out = !timer_extended_status_ff[STAT_T0OE]
		&& agree(t0_sync_ff) && t0_level_ff && !t0_sync_ff[2];
	assign timer1_count_event_out = !timer_extended_status_ff[STAT_T1OE]
		&& agree(t1_sync_ff) && t1_level_ff && !t1_sync_ff[2];

	// Internal timer clock prescaler
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) prescale_ff <= 8'h00;
		else if (tick) prescale_ff <= 8'h00;
		else prescale_ff <= prescale_ff + 8'h01;
	end
	assign tick = (prescale_ff == 8'(PRESCALE - 1));

	assign baud_sel = timer2_control_ff[CTL_UART0_RX_CLOCK_SELECT] | timer2_control_ff[CTL_UART0_TX_CLOCK_SELECT]
		| timer2_mode_register_ff[MOD_UART1_RX_CLOCK_SELECT] | timer2_mode_register_ff[MOD_UART1_TX_CLOCK_SELECT];

	always_comb begin
		if (!timer2_control_ff[CTL_RUN]) mode = T2CTL_MODE_OFF;
		else if (baud_sel) mode = T2CTL_MODE_BAUD;
		else if (timer2_control_ff[CTL_CAP]) mode = T2CTL_MODE_CAPTURE;
		else mode = T2CTL_MODE_RELOAD;
	end

	// Counter-select picks internal ticks or external falling edges
	assign step = (mode != T2CTL_MODE_OFF)
		&& (timer2_control_ff[CTL_CNT] ? t2_fall : tick);
	wire down_mode = (mode == T2CTL_MODE_RELOAD) && timer2_mode_register_ff[MOD_DOWN_COUNT_ENABLE];
	wire count_down = down_mode && !trig_high;
	assign up_wrap = step && !count_down && (count_ff == COUNT_ALL_ONES);
	assign down_hit = step && count_down && (count_ff == reload_ff);
	assign ovf_event = up_wrap || down_hit;
	assign ext_event = timer2_control_ff[CTL_EXEN] && trig_fall && !down_mode
		&& (mode == T2CTL_MODE_CAPTURE || mode == T2CTL_MODE_RELOAD);

	always_comb begin
		nxt_count = count_ff;
		if (down_hit) nxt_count = COUNT_ALL_ONES;
		else if (up_wrap) begin
			if (mode == T2CTL_MODE_CAPTURE) nxt_count = 16'h0000;
			else nxt_count = reload_ff;
		end else if (step) nxt_count = count_down ? count_ff - 16'h0001 : count_ff + 16'h0001;
		if (ext_event && mode == T2CTL_MODE_RELOAD) nxt_count = reload_ff;
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) count_ff <= 16'h0000;
		else if (sfr_wr_in && sfr_addr_in == COUNT_LOW_OFFSET) count_ff[7:0] <= sfr_wdata_in;
		else if (sfr_wr_in && sfr_addr_in == COUNT_HIGH_OFFSET) count_ff[15:8] <= sfr_wdata_in;
		else count_ff <= nxt_count;
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) capture_ff <= 16'h0000;
		else if (ext_event && mode == T2CTL_MODE_CAPTURE) capture_ff <= count_ff;
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) reload_ff <= 16'h0000;
		else if (sfr_wr_in && sfr_addr_in == RELOAD_LOW_OFFSET) reload_ff[7:0] <= sfr_wdata_in;
		else if (sfr_wr_in && sfr_addr_in == RELOAD_HIGH_OFFSET) reload_ff[15:8] <= sfr_wdata_in;
	end

	// Control register; hardware set wins over a same-cycle software clear
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) timer2_control_ff <= TIMER2_CONTROL_RESET;
		else begin
			if (sfr_wr_in && sfr_addr_in == TIMER2_CONTROL_OFFSET) timer2_control_ff <= sfr_wdata_in;
			if (ovf_event && !baud_sel && !timer2_mode_register_ff[MOD_CLKOE])
				timer2_control_ff[CTL_OVF] <= 1'b1;
			if (ext_event) timer2_control_ff[CTL_EXF] <= 1'b1;
			else if (down_mode && ovf_event)
				timer2_control_ff[CTL_EXF] <= ~timer2_control_ff[CTL_EXF];
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) timer2_mode_register_ff <= TIMER2_MODE_RESET;
		else if (sfr_wr_in && sfr_addr_in == TIMER2_MODE_OFFSET)
			timer2_mode_register_ff <= sfr_wdata_in & 8'h33;
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) timer_extended_status_ff <= TIMER_EXT_STATUS_RESET;
		else if (sfr_wr_in && sfr_addr_in == TIMER_EXT_STATUS_OFFSET)
			timer_extended_status_ff <= sfr_wdata_in & 8'h05;
	end

	// External flag in down-count mode is only a 17th bit, not an interrupt source
	assign timer2_irq_out = timer2_int_enable_in && (timer2_control_ff[CTL_OVF]
		|| (timer2_control_ff[CTL_EXF] && !down_mode));

	// Overflow pulse towards the UART clock selects
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) ovf_pulse_ff <= 1'b0;
		else ovf_pulse_ff <= ovf_event && (mode == T2CTL_MODE_BAUD);
	end
	assign uart0_rx_clock_out = ovf_pulse_ff && timer2_control_ff[CTL_UART0_RX_CLOCK_SELECT];
	assign uart0_tx_clock_out = ovf_pulse_ff && timer2_control_ff[CTL_UART0_TX_CLOCK_SELECT];
	assign uart1_rx_clock_out = ovf_pulse_ff && timer2_mode_register_ff[MOD_UART1_RX_CLOCK_SELECT];
	assign uart1_tx_clock_out = ovf_pulse_ff && timer2_mode_register_ff[MOD_UART1_TX_CLOCK_SELECT];

	// Toggle outputs for timers 0 and 1
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) toggle_ff <= 2'b00;
		else begin
			if (timer0_overflow_in) toggle_ff[0] <= ~toggle_ff[0];
			if (timer1_overflow_in) toggle_ff[1] <= ~toggle_ff[1];
		end
	end
	// Pin carries latch or toggle; driven only as output when toggle enabled
	assign timer0_pin_out = timer_extended_status_ff[STAT_T0OE] ? toggle_ff[0]
		: timer0_port_latch_in;
	assign timer1_pin_out = timer_extended_status_ff[STAT_T1OE] ? toggle_ff[1]
		: timer1_port_latch_in;
	assign timer0_pin_oe_out = timer_extended_status_ff[STAT_T0OE];
	assign timer1_pin_oe_out = timer_extended_status_ff[STAT_T1OE];

	always_comb begin
		unique case (sfr_addr_in)
			TIMER2_CONTROL_OFFSET: sfr_rdata_out = timer2_control_ff;
			TIMER2_MODE_OFFSET: sfr_rdata_out = timer2_mode_register_ff;
			TIMER_EXT_STATUS_OFFSET: sfr_rdata_out = timer_extended_status_ff;
			COUNT_LOW_OFFSET: sfr_rdata_out = count_ff[7:0];
			COUNT_HIGH_OFFSET: sfr_rdata_out = count_ff[15:8];
			RELOAD_LOW_OFFSET: sfr_rdata_out = reload_ff[7:0];
			RELOAD_HIGH_OFFSET: sfr_rdata_out = reload_ff[15:8];
			CAPTURE_LOW_OFFSET: sfr_rdata_out = capture_ff[7:0];
			CAPTURE_HIGH_OFFSET: sfr_rdata_out = capture_ff[15:8];
			default: sfr_rdata_out = 8'h00;
		endcase
	end
endmodule : t2ctl_timer2

// >>> testbench/t2ctl_pins_model.sv
// Far-side pins: count pin, trigger pin, shared timer 0/1 pins.
// Assumes the bench calls its tasks; released pins sit at a pull-up.
module t2ctl_pins_model (
	input wire logic clk_in,
	input wire logic t0_drive_in,
	input wire logic t0_oe_in,
	input wire logic t1_drive_in,
	input wire logic t1_oe_in,
	output logic t0_wire_out,
	output logic t1_wire_out,
	output logic t2_pin_out = 1'b1,
	output logic trigger_out = 1'b1
);
	timeunit 1ns;
	timeprecision 100ps;
	logic t0_ext = 1'b1;
	assign t0_wire_out = t0_oe_in ? t0_drive_in : t0_ext;
	assign t1_wire_out = t1_oe_in ? t1_drive_in : t0_ext;
	task lvl(input logic v);
		@(posedge clk_in);
		#1;
		trigger_out = v;
	endtask : lvl
	// Low pulse: 0 both timer 0/1 pins, 1 count pin, else trigger
	task dip(input int k);
		lvl(k > 1 ? 1'b0 : trigger_out);
		t0_ext = k != 0;
		t2_pin_out = k != 1;
		repeat (6) @(posedge clk_in);
		#1;
		t0_ext = 1'b1;
		t2_pin_out = 1'b1;
		trigger_out = 1'b1;
		repeat (6) @(posedge clk_in);
	endtask : dip
endmodule : t2ctl_pins_model

// >>> testbench/t2ctl_props.sv
// Port checker for the timer 2 block.
// Assumes a bind onto t2ctl_timer2, one clk_in domain.
module t2ctl_props
	import t2ctl_pkg::*;
#(parameter int PRESCALE = PRESCALE_DEFAULT) (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic [10:0] sfr_addr_in,
	input wire logic sfr_wr_in,
	input wire logic [7:0] sfr_wdata_in,
	input wire logic [7:0] sfr_rdata_out,
	input wire logic timer0_overflow_in,
	input wire logic timer1_overflow_in,
	input wire logic timer0_pin_out,
	input wire logic timer0_pin_oe_out,
	input wire logic timer1_pin_out,
	input wire logic timer1_pin_oe_out,
	input wire logic timer0_count_event_out,
	input wire logic timer1_count_event_out,
	input wire logic timer2_int_enable_in,
	input wire logic timer2_irq_out,
	input wire logic uart0_rx_clock_out
);
	logic c2;
	logic md;
	logic st;
	assign c2 = sfr_addr_in == TIMER2_CONTROL_OFFSET;
	assign md = sfr_addr_in == TIMER2_MODE_OFFSET;
	assign st = sfr_addr_in == TIMER_EXT_STATUS_OFFSET;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);
	a_irq_masked: assert property (!timer2_int_enable_in |-> !timer2_irq_out)
		else $error("irq while disabled");
	a_irq_from_flag: assert property (c2 && sfr_rdata_out[CTL_OVF]
		&& timer2_int_enable_in |-> timer2_irq_out)
		else $error("flag set but no irq");
	a_ovf_flag_held: assert property (c2 && sfr_rdata_out[CTL_OVF]
		&& !sfr_wr_in ##1 c2 |-> sfr_rdata_out[CTL_OVF])
		else $error("overflow flag dropped");
	a_t0_toggle_flip: assert property (timer0_pin_oe_out && timer0_overflow_in
		##1 timer0_pin_oe_out |-> timer0_pin_out != $past(timer0_pin_out))
		else $error("timer0 pin missed toggle");
	a_t1_toggle_flip: assert property (timer1_pin_oe_out && timer1_overflow_in
		##1 timer1_pin_oe_out |-> timer1_pin_out != $past(timer1_pin_out))
		else $error("timer1 pin missed toggle");
	a_t0_event_gate: assert property (timer0_pin_oe_out |-> !timer0_count_event_out)
		else $error("timer0 count while output");
	a_t1_event_gate: assert property (timer1_pin_oe_out |-> !timer1_count_event_out)
		else $error("timer1 count while output");
	a_mode_read_back: assert property (sfr_wr_in && md ##1 md
		|-> sfr_rdata_out == ($past(sfr_wdata_in) & 8'h33))
		else $error("mode read back wrong");
	a_stat_read_back: assert property (sfr_wr_in && st ##1 st
		|-> sfr_rdata_out == ($past(sfr_wdata_in) & 8'h05))
		else $error("status read back wrong");
	cover property (uart0_rx_clock_out);
	cover property (timer0_count_event_out);
	cover property (timer2_irq_out);
endmodule : t2ctl_props

bind t2ctl_timer2 t2ctl_props #(.PRESCALE(PRESCALE)) u_t2ctl_props (.clk_in(clk_in),
	.reset_n_in(reset_n_in), .sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in),
	.sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out),
	.timer0_overflow_in(timer0_overflow_in), .timer1_overflow_in(timer1_overflow_in),
	.timer0_pin_out(timer0_pin_out), .timer0_pin_oe_out(timer0_pin_oe_out),
	.timer1_pin_out(timer1_pin_out), .timer1_pin_oe_out(timer1_pin_oe_out),
	.timer0_count_event_out(timer0_count_event_out),
	.timer1_count_event_out(timer1_count_event_out),
	.timer2_int_enable_in(timer2_int_enable_in), .timer2_irq_out(timer2_irq_out),
	.uart0_rx_clock_out(uart0_rx_clock_out));

// >>> testbench/tb.sv
// Self-checking bench for t2ctl_timer2, PRESCALE set to 1.
// Assumes the pin model and the bound checker are compiled alongside.
module tb
	import t2ctl_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic sfr_wr_in = 1'b0;
	logic [10:0] sfr_addr_in = 11'h0;
	logic [7:0] sfr_wdata_in = 8'h00;
	logic timer0_overflow_in = 1'b0;
	logic timer1_overflow_in = 1'b0;
	logic timer2_int_enable_in = 1'b0;
	logic timer0_port_latch_in = 1'b0;
	logic timer1_port_latch_in = 1'b1;
	logic [7:0] sfr_rdata_out;
	logic t2_pin_in, trigger_input_in, timer0_pin_in, timer1_pin_in, timer0_pin_out;
	logic timer0_pin_oe_out, timer1_pin_out, timer1_pin_oe_out, timer0_count_event_out;
	logic timer1_count_event_out, timer2_irq_out, uart0_rx_clock_out, uart0_tx_clock_out;
	logic uart1_rx_clock_out, uart1_tx_clock_out;
	logic [5:0] ev;
	int fails = 0;
	int samples_checked = 0;
	localparam logic [10:0] CTL = TIMER2_CONTROL_OFFSET;
	assign ev = {timer1_count_event_out, uart1_rx_clock_out, uart0_tx_clock_out,
		timer0_count_event_out, uart1_tx_clock_out, uart0_rx_clock_out};
	t2ctl_timer2 #(.PRESCALE(1)) u_t2ctl_timer2 (.clk_in(clk_in),
		.reset_n_in(reset_n_in), .sfr_addr_in(sfr_addr_in),
		.sfr_wr_in(sfr_wr_in), .sfr_wdata_in(sfr_wdata_in),
		.sfr_rdata_out(sfr_rdata_out), .t2_pin_in(t2_pin_in),
		.trigger_input_in(trigger_input_in),
		.timer0_overflow_in(timer0_overflow_in),
		.timer1_overflow_in(timer1_overflow_in),
		.timer0_port_latch_in(timer0_port_latch_in),
		.timer1_port_latch_in(timer1_port_latch_in),
		.timer0_pin_in(timer0_pin_in), .timer1_pin_in(timer1_pin_in),
		.timer0_pin_out(timer0_pin_out), .timer0_pin_oe_out(timer0_pin_oe_out),
		.timer1_pin_out(timer1_pin_out), .timer1_pin_oe_out(timer1_pin_oe_out),
		.timer0_count_event_out(timer0_count_event_out),
		.timer1_count_event_out(timer1_count_event_out),
		.timer2_int_enable_in(timer2_int_enable_in),
		.timer2_irq_out(timer2_irq_out),
		.uart0_rx_clock_out(uart0_rx_clock_out),
		.uart0_tx_clock_out(uart0_tx_clock_out),
		.uart1_rx_clock_out(uart1_rx_clock_out),
		.uart1_tx_clock_out(uart1_tx_clock_out));
	t2ctl_pins_model u_t2ctl_pins_model (.clk_in(clk_in), .t0_drive_in(timer0_pin_out),
		.t0_oe_in(timer0_pin_oe_out), .t1_drive_in(timer1_pin_out),
		.t1_oe_in(timer1_pin_oe_out), .t0_wire_out(timer0_pin_in),
		.t1_wire_out(timer1_pin_in), .t2_pin_out(t2_pin_in), .trigger_out(trigger_input_in));
	initial forever #4 clk_in = ~clk_in;
	task cmp(input string n, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			fails++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask : cmp
	task ck(input string n, input logic [10:0] a, input logic [7:0] e);
		@(posedge clk_in);
		#1;
		sfr_addr_in = a;
		#1;
		cmp(n, e, sfr_rdata_out);
	endtask : ck
	task wr(input logic [10:0] a, input logic [7:0] d);
		@(posedge clk_in);
		#1;
		sfr_addr_in = a;
		sfr_wdata_in = d;
		sfr_wr_in = 1'b1;
		@(posedge clk_in);
		#1;
		sfr_wr_in = 1'b0;
	endtask : wr
	task w16(input logic [10:0] a, input logic [15:0] v);
		wr(a, v[7:0]);
		wr(a + 11'h1, v[15:8]);
	endtask : w16
	task wt(input string n, input int k);
		for (int i = 0; i < 20 && ev[k] !== 1'b1; i++) begin
			@(posedge clk_in);
			#1;
		end
		cmp(n, 8'h01, {7'h0, ev[k]});
	endtask : wt
	task s_reset;
		ck("ctl_rst", CTL, TIMER2_CONTROL_RESET);
		ck("mod_rst", TIMER2_MODE_OFFSET, TIMER2_MODE_RESET);
		ck("stat_rst", TIMER_EXT_STATUS_OFFSET, TIMER_EXT_STATUS_RESET);
		wr(TIMER2_MODE_OFFSET, 8'hff);
		ck("mod_bits", TIMER2_MODE_OFFSET, 8'h33);
		wr(TIMER2_MODE_OFFSET, 8'h00);
		wr(TIMER_EXT_STATUS_OFFSET, 8'hff);
		ck("stat_bits", TIMER_EXT_STATUS_OFFSET, 8'h05);
		wr(11'h7ff, 8'haa);
		ck("unmapped", 11'h7ff, 8'h00);
	endtask : s_reset
	task s_toggle;
		logic p0;
		logic p1;
		@(posedge clk_in);
		#1;
		p0 = timer0_pin_out;
		p1 = timer1_pin_out;
		timer0_overflow_in = 1'b1;
		timer1_overflow_in = 1'b1;
		@(posedge clk_in);
		#1;
		timer0_overflow_in = 1'b0;
		timer1_overflow_in = 1'b0;
		cmp("t0_toggle", {7'h0, ~p0}, {7'h0, timer0_pin_out});
		cmp("t1_toggle", {7'h0, ~p1}, {7'h0, timer1_pin_out});
		cmp("t0_oe", 8'h01, {7'h0, timer0_pin_oe_out});
		wr(TIMER_EXT_STATUS_OFFSET, 8'h00);
		cmp("t0_latch", 8'h00, {7'h0, timer0_pin_out});
		timer0_port_latch_in = 1'b1;
		timer1_port_latch_in = 1'b0;
		#1;
		cmp("t0_latch_hi", 8'h01, {7'h0, timer0_pin_out});
		cmp("t1_latch", 8'h00, {7'h0, timer1_pin_out});
		cmp("t1_oe_off", 8'h00, {7'h0, timer1_pin_oe_out});
		fork
			u_t2ctl_pins_model.dip(0);
			wt("t0_event", 2);
			wt("t1_event", 5);
		join
	endtask : s_toggle
	task s_reload;
		w16(RELOAD_LOW_OFFSET, 16'hfffd);
		w16(COUNT_LOW_OFFSET, 16'hfffd);
		timer2_int_enable_in = 1'b1;
		wr(CTL, 8'h04);
		repeat (4) @(posedge clk_in);
		ck("ovf_set", CTL, 8'h84);
		cmp("irq_on", 8'h01, {7'h0, timer2_irq_out});
		ck("reload_hi", COUNT_HIGH_OFFSET, 8'hff);
		wr(CTL, 8'h00);
		ck("ovf_clr", CTL, 8'h00);
		cmp("irq_off", 8'h00, {7'h0, timer2_irq_out});
		wr(COUNT_LOW_OFFSET, 8'h00);
		repeat (5) @(posedge clk_in);
		ck("stopped", COUNT_LOW_OFFSET, 8'h00);
		// Pin-counted with an idle pin, so only the trigger moves the count
		wr(CTL, 8'h0e);
		u_t2ctl_pins_model.dip(2);
		ck("trig_reload", COUNT_LOW_OFFSET, 8'hfd);
		ck("exf_reload", CTL, 8'h4e);
		cmp("irq_exf_rl", 8'h01, {7'h0, timer2_irq_out});
		wr(CTL, 8'h00);
	endtask : s_reload
	task s_capture;
		w16(COUNT_LOW_OFFSET, 16'h1234);
		wr(CTL, 8'h0f);
		repeat (5) @(posedge clk_in);
		ck("ext_hold", COUNT_LOW_OFFSET, 8'h34);
		u_t2ctl_pins_model.dip(2);
		ck("cap_lo", CAPTURE_LOW_OFFSET, 8'h34);
		ck("cap_hi", CAPTURE_HIGH_OFFSET, 8'h12);
		ck("exf_set", CTL, 8'h4f);
		cmp("irq_exf", 8'h01, {7'h0, timer2_irq_out});
		repeat (3) u_t2ctl_pins_model.dip(1);
		ck("ext_count", COUNT_LOW_OFFSET, 8'h37);
		ck("exf_hold", CTL, 8'h4f);
		wr(CTL, 8'h0f);
		ck("exf_clr", CTL, 8'h0f);
		wr(CTL, 8'h00);
	endtask : s_capture
	task s_baud;
		w16(RELOAD_LOW_OFFSET, 16'hfffe);
		w16(COUNT_LOW_OFFSET, 16'hfffe);
		wr(CTL, 8'h35);
		wt("u0_rx", 0);
		wt("u0_tx", 3);
		ck("no_ovf", CTL, 8'h35);
		wr(TIMER2_MODE_OFFSET, 8'h30);
		wt("u1_tx", 1);
		wt("u1_rx", 4);
		wr(TIMER2_MODE_OFFSET, 8'h00);
		wr(CTL, 8'h00);
	endtask : s_baud
	task s_down;
		wr(TIMER2_MODE_OFFSET, 8'h01);
		w16(RELOAD_LOW_OFFSET, 16'h0010);
		w16(COUNT_LOW_OFFSET, 16'h0012);
		u_t2ctl_pins_model.lvl(1'b0);
		wr(CTL, 8'h04);
		repeat (6) @(posedge clk_in);
		ck("down_hi", COUNT_HIGH_OFFSET, 8'hff);
		ck("underflow", CTL, 8'hc4);
		u_t2ctl_pins_model.lvl(1'b1);
		repeat (30) @(posedge clk_in);
		ck("up_hi", COUNT_HIGH_OFFSET, 8'h00);
		ck("up_flag", CTL, 8'h84);
		wr(CTL, 8'h00);
		wr(TIMER2_MODE_OFFSET, 8'h00);
	endtask : s_down
	task tally_and_finish;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		#100us;
		fails++;
		tally_and_finish();
	end
	initial begin
		repeat (12) @(posedge clk_in);
		#1;
		reset_n_in = 1'b1;
		s_reset();
		s_toggle();
		s_reload();
		s_capture();
		s_baud();
		s_down();
		tally_and_finish();
	end
endmodule : tb
